// >>> pdc_defs.vh
// Constants for the chained potentiometer host controller
// Assumes a 100 MHz system clock and a two-device chain
`ifndef PDC_DEFS_VH
`define PDC_DEFS_VH
`define PDC_WORD_BITS 7
`define PDC_CHAIN_DEVS 2
`define PDC_FRAME_BITS 14
`define PDC_MIDSCALE 7'h40
`define PDC_ZERO_SCALE 7'h00
`define PDC_CLK_HALF_DEF 8
`define PDC_CS_GAP_DEF 8
`define PDC_RST_PULSE_DEF 8
`define PDC_GATE_PULSES 2
`endif

// >>> pdc_buf2.v
// Two-entry buffer with valid and ready on both sides
// Assumes one clock domain and synchronous active-high reset
`timescale 1ns/1ps
module pdc_buf2 #(
  parameter W = 14
) (
  input wire clk,
  input wire srst,
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data
);
  reg [W-1:0] mem_r [0:1];
  reg wp_r;
  reg rp_r;
  reg [1:0] cnt_r;
  wire push;
  wire pop;
  assign in_ready = (cnt_r != 2'h2);
  assign out_valid = (cnt_r != 2'h0);
  assign out_data = mem_r[rp_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always @(posedge clk) begin
    if (srst) begin
      wp_r <= 1'b0;
      rp_r <= 1'b0;
      cnt_r <= 2'h0;
    end else begin
      if (push) begin
        wp_r <= ~wp_r;
      end
      if (pop) begin
        rp_r <= ~rp_r;
      end
      if (push && !pop) begin
        cnt_r <= cnt_r + 2'h1;
      end else if (pop && !push) begin
        cnt_r <= cnt_r - 2'h1;
      end
    end
  end
  always @(posedge clk) begin
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end
endmodule // pdc_buf2

// >>> pdc_sync3.v
// Three-stage pin synchroniser; change accepted when stages two and three agree
// Assumes an asynchronous input and synchronous active-high reset
`timescale 1ns/1ps
module pdc_sync3 (
  input wire clk,
  input wire srst,
  input wire pin,
  output reg level
);
  reg s1_r;
  reg s2_r;
  reg s3_r;
  always @(posedge clk) begin
    if (srst) begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
      s3_r <= 1'b1;
      level <= 1'b1;
    end else begin
      s1_r <= pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        level <= s3_r;
      end
    end
  end
endmodule // pdc_sync3

// >>> pdc_host.v
// Host controller driving a two-device chain of 128-position potentiometers
// Assumes clk at 100 MHz, pull-up on the chain output, devices clock on rising edge
// Assumes one shutdown line for the whole chain, so the far device reads ones while shut down
//
// Overview of operation
// - Every update clocks fourteen data bits within one chip-select low period.
// - The far device's seven bits are sent first, then the near device's seven.
// - Chip select stays low without a break until all fourteen bits are clocked.
// - Chip select rises after the last bit, loading each device's setting latch.
// - The serial clock period is lengthened so pull-up edges settle in the chain.
// - Chip select may be ANDed with a zero-crossing window for click-free updates.
// - With zero-crossing gating, chip select is issued as two separate pulses.
// - For mute at power-up, shutdown is held low while zero scale is written.
// - Words go most significant bit first, one bit per rising shift clock edge.
`timescale 1ns/1ps
`include "pdc_defs.vh"
module pdc_host #(
  parameter CLK_HALF = `PDC_CLK_HALF_DEF,
  parameter CS_GAP = `PDC_CS_GAP_DEF,
  parameter RST_PULSE = `PDC_RST_PULSE_DEF
) (
  input wire clk,
  input wire srst,
  input wire wr_valid,
  output wire wr_ready,
  input wire [6:0] wr_far,
  input wire [6:0] wr_near,
  input wire wr_zc_gate,
  input wire mute_req,
  input wire midscale_req,
  input wire unmute_req,
  input wire zc_window,
  input wire chain_return_pin,
  output reg [13:0] rd_data,
  output reg rd_valid,
  output wire busy,
  output reg cs_n,
  output reg sclk,
  output reg serial_in_pin,
  output reg midscale_reset_n,
  output reg shutdown_n
);
  localparam [6:0] S_IDLE = 7'h01;
  localparam [6:0] S_SETUP = 7'h02;
  localparam [6:0] S_LOW = 7'h04;
  localparam [6:0] S_HIGH = 7'h08;
  localparam [6:0] S_END = 7'h10;
  localparam [6:0] S_GAP = 7'h20;
  localparam [6:0] S_RST = 7'h40;
  localparam [4:0] NBITS = `PDC_FRAME_BITS;
  localparam [15:0] HALF = CLK_HALF;
  localparam [15:0] GAP = CS_GAP;
  localparam [15:0] RSTW = RST_PULSE;
  localparam [4:0] LAST_BIT = NBITS - 5'h01;

  reg [6:0] st_r;
  reg [15:0] tmr_r;
  reg [4:0] bit_r;
  reg [13:0] sh_r;
  reg [13:0] cap_r;
  reg gate_r;
  reg pulse_r;
  reg mute_pend_r;

  // Next values
  reg [6:0] st_nxt;
  reg [15:0] tmr_nxt;
  reg [4:0] bit_nxt;
  reg [13:0] sh_nxt;
  reg [13:0] cap_nxt;
  reg gate_nxt;
  reg pulse_nxt;
  reg mute_pend_nxt;
  reg cs_n_nxt;
  reg sclk_nxt;
  reg sin_nxt;
  reg mrst_n_nxt;
  reg shutdown_n_n_nxt;
  reg [13:0] rd_data_nxt;
  reg rd_valid_nxt;

  wire ret_lvl;
  wire b_valid;
  wire b_ready;
  wire [13:0] b_data;
  wire b_gate;
  wire [14:0] b_word;

  assign busy = (st_r != S_IDLE);
  // Buffer pops only when neither a midscale pulse nor a mute frame goes first
  assign b_ready = (st_r == S_IDLE) && !midscale_req && !(mute_pend_r && !mute_req);

  pdc_sync3 u_ret (
    .clk(clk),
    .srst(srst),
    .pin(chain_return_pin),
    .level(ret_lvl)
  );

  // Far word in the upper half so it leaves first
  pdc_buf2 #(.W(15)) u_buf (
    .clk(clk),
    .srst(srst),
    .in_valid(wr_valid),
    .in_ready(wr_ready),
    .in_data({wr_zc_gate, wr_far, wr_near}),
    .out_valid(b_valid),
    .out_ready(b_ready),
    .out_data(b_word)
  );

  // One seven-bit slot per device, the far device in the top slot
  genvar g;
  generate
    for (g = 0; g < `PDC_CHAIN_DEVS; g = g + 1) begin : g_slot
      assign b_data[g*`PDC_WORD_BITS +: `PDC_WORD_BITS] = b_word[g*`PDC_WORD_BITS +: `PDC_WORD_BITS];
    end
  endgenerate
  assign b_gate = b_word[14];

  // Next-state and pin values
  always @* begin
    st_nxt = st_r;
    tmr_nxt = tmr_r;
    bit_nxt = bit_r;
    sh_nxt = sh_r;
    cap_nxt = cap_r;
    gate_nxt = gate_r;
    pulse_nxt = pulse_r;
    mute_pend_nxt = mute_pend_r;
    cs_n_nxt = cs_n;
    sclk_nxt = sclk;
    sin_nxt = serial_in_pin;
    mrst_n_nxt = midscale_reset_n;
    shutdown_n_n_nxt = shutdown_n;
    rd_data_nxt = rd_data;
    rd_valid_nxt = 1'b0;
    // Shutdown follows mute and unmute requests
    if (mute_req) begin
      shutdown_n_n_nxt = 1'b0;
      mute_pend_nxt = 1'b1;
    end else if (unmute_req && !mute_pend_r) begin
      shutdown_n_n_nxt = 1'b1;
    end
    case (st_r)
      // Wait for work: midscale first, then the mute frame, then the buffer
      S_IDLE: begin
        cs_n_nxt = 1'b1;
        sclk_nxt = 1'b0;
        if (midscale_req) begin
          mrst_n_nxt = 1'b0;
          tmr_nxt = RSTW;
          st_nxt = S_RST;
        end else if (mute_pend_r && !mute_req) begin
          // Zero scale shifted out; the near device gets it, the far device reads ones while shutdown holds
          sh_nxt = {`PDC_ZERO_SCALE, `PDC_ZERO_SCALE};
          gate_nxt = 1'b0;
          mute_pend_nxt = 1'b0;
          st_nxt = S_SETUP;
          tmr_nxt = HALF;
        end else if (b_valid) begin
          sh_nxt = b_data;
          gate_nxt = b_gate;
          pulse_nxt = 1'b0;
          st_nxt = S_SETUP;
          tmr_nxt = HALF;
        end
        bit_nxt = 5'h00;
      end
      // Chip select low, first bit set up before the first rise
      S_SETUP: begin
        cs_n_nxt = 1'b0;
        sin_nxt = sh_r[13];
        if (tmr_r == 16'h0000) begin
          tmr_nxt = HALF;
          st_nxt = S_LOW;
        end else begin
          tmr_nxt = tmr_r - 16'h0001;
        end
      end
      S_LOW: begin
        // Half period of HALF+1 cycles gives settle time on chain links
        if (tmr_r == 16'h0000) begin
          sclk_nxt = 1'b1;
          tmr_nxt = HALF;
          st_nxt = S_HIGH;
        end else begin
          tmr_nxt = tmr_r - 16'h0001;
        end
      end
      // Shift clock high; data moves only on its fall
      S_HIGH: begin
        if (tmr_r == 16'h0000) begin
          sclk_nxt = 1'b0;
          // Capture returned bit from chain near the end of high phase
          cap_nxt = {cap_r[12:0], ret_lvl};
          sh_nxt = {sh_r[12:0], 1'b0};
          sin_nxt = sh_r[12];
          tmr_nxt = HALF;
          if (bit_r == LAST_BIT) begin
            st_nxt = S_END;
          end else begin
            bit_nxt = bit_r + 5'h01;
            st_nxt = S_LOW;
          end
        end else begin
          tmr_nxt = tmr_r - 16'h0001;
        end
      end
      // Last half period, then chip select rises
      S_END: begin
        if (tmr_r == 16'h0000) begin
          // Gated updates wait for the zero-crossing window
          if (!gate_r || zc_window) begin
            cs_n_nxt = 1'b1;
            rd_data_nxt = cap_r;
            rd_valid_nxt = !pulse_r;
            tmr_nxt = GAP;
            st_nxt = S_GAP;
          end
        end else begin
          tmr_nxt = tmr_r - 16'h0001;
        end
      end
      // Chip select high between frames
      S_GAP: begin
        cs_n_nxt = 1'b1;
        if (tmr_r == 16'h0000) begin
          if (gate_r && !pulse_r) begin
            // Second chip-select pulse under zero-crossing gating
            pulse_nxt = 1'b1;
            cs_n_nxt = 1'b0;
            tmr_nxt = HALF;
            st_nxt = S_END;
          end else begin
            pulse_nxt = 1'b0;
            st_nxt = S_IDLE;
          end
        end else begin
          tmr_nxt = tmr_r - 16'h0001;
        end
      end
      S_RST: begin
        // Release with chip select high; the wipers took midscale when the reset line fell
        if (tmr_r == 16'h0000) begin
          mrst_n_nxt = 1'b1;
          tmr_nxt = GAP;
          st_nxt = S_GAP;
        end else begin
          tmr_nxt = tmr_r - 16'h0001;
        end
      end
      default: begin
        st_nxt = S_IDLE;
        cs_n_nxt = 1'b1;
      end
    endcase
  end

  // Registered state and pins; reset values match the idle pins
  always @(posedge clk) begin
    if (srst) begin
      st_r <= S_IDLE;
      tmr_r <= 16'h0000;
      bit_r <= 5'h00;
      sh_r <= 14'h0000;
      cap_r <= 14'h0000;
      gate_r <= 1'b0;
      pulse_r <= 1'b0;
      mute_pend_r <= 1'b0;
      cs_n <= 1'b1;
      sclk <= 1'b0;
      serial_in_pin <= 1'b0;
      midscale_reset_n <= 1'b1;
      shutdown_n <= 1'b1;
      rd_data <= 14'h0000;
      rd_valid <= 1'b0;
    end else begin
      // Commit next values
      st_r <= st_nxt;
      tmr_r <= tmr_nxt;
      bit_r <= bit_nxt;
      sh_r <= sh_nxt;
      cap_r <= cap_nxt;
      gate_r <= gate_nxt;
      pulse_r <= pulse_nxt;
      mute_pend_r <= mute_pend_nxt;
      cs_n <= cs_n_nxt;
      sclk <= sclk_nxt;
      serial_in_pin <= sin_nxt;
      midscale_reset_n <= mrst_n_nxt;
      shutdown_n <= shutdown_n_n_nxt;
      rd_data <= rd_data_nxt;
      rd_valid <= rd_valid_nxt;
    end
  end
endmodule // pdc_host

// >>> pdc_chain_model.sv
// Two chained potentiometer serial ports
// Assumes host pins in, pull-up on the return wire
`timescale 1ns/1ps
module pdc_chain_model (
  input wire cs_n,
  input wire sclk,
  input wire serial_in_pin,
  input wire midscale_reset_n,
  input wire shutdown_n,
  output wire chain_serial_out,
  output reg [6:0] near_wiper = 7'h00,
  output reg [6:0] far_wiper = 7'h00
);
  reg [6:0] near_sh = 7'h00;
  reg [6:0] far_sh = 7'h00;
  reg near_o = 1'b0;
  reg far_o = 1'b0;
  wire link = near_o | ~shutdown_n;
  assign chain_serial_out = far_o | ~shutdown_n;
  always @(posedge sclk) if (!cs_n && midscale_reset_n) begin
    near_sh <= {near_sh[5:0], serial_in_pin};
    far_sh <= {far_sh[5:0], link};
  end
  always @(negedge sclk) if (!cs_n && midscale_reset_n) begin
    near_o <= near_sh[6];
    far_o <= far_sh[6];
  end
  always @(posedge cs_n) if (midscale_reset_n) begin
    near_wiper <= near_sh;
    far_wiper <= far_sh;
  end
  always @(midscale_reset_n) if (!midscale_reset_n) begin
    near_wiper <= 7'h40;
    far_wiper <= 7'h40;
    near_o <= 1'b0;
    far_o <= 1'b0;
  end
endmodule // pdc_chain_model

// >>> pdc_host_checker.sv
// Pin timing checks for the chain host
// Assumes binding into pdc_host
`timescale 1ns/1ps
module pdc_host_checker #(
  parameter CLK_HALF = 8,
  parameter CS_GAP = 8,
  parameter RST_PULSE = 8
) (
  input wire clk,
  input wire srst,
  input wire rd_valid,
  input wire cs_n,
  input wire sclk,
  input wire serial_in_pin,
  input wire midscale_reset_n
);
  reg sclk_q;
  reg cs_q;
  reg [7:0] run;
  reg [7:0] rises;
  reg [7:0] low;
  always @(posedge clk) begin
    sclk_q <= sclk;
    cs_q <= cs_n;
    run <= srst ? 8'hff : (sclk != sclk_q || cs_n != cs_q) ? 8'h01 : run + {7'h00, run != 8'hff};
    rises <= cs_n ? 8'h00 : rises + {7'h00, sclk & ~sclk_q};
    low <= (midscale_reset_n || srst) ? 8'h00 : low + 8'h01;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  property p_idle; cs_n |-> !sclk; endproperty
  a_idle: assert property (p_idle) else $error("clock outside frame");
  property p_hold; $rose(sclk) |-> $stable(serial_in_pin); endproperty
  a_hold: assert property (p_hold) else $error("data moved at rise");
  property p_high; $fell(sclk) |-> run == CLK_HALF + 1; endproperty
  a_high: assert property (p_high) else $error("high phase length");
  property p_low;
    $rose(sclk) |-> !cs_n && run == (rises == 8'h00 ? 2 * CLK_HALF + 1 : CLK_HALF + 1);
  endproperty
  a_low: assert property (p_low) else $error("low phase length");
  property p_bits; rd_valid |-> $rose(cs_n) && rises == 8'h0e; endproperty
  a_bits: assert property (p_bits) else $error("bit count");
  property p_gap; $fell(cs_n) |-> run >= CS_GAP + 1; endproperty
  a_gap: assert property (p_gap) else $error("select gap");
  property p_once; rd_valid |=> !rd_valid ##1 !rd_valid; endproperty
  a_once: assert property (p_once) else $error("result pulse");
  property p_mid; $rose(midscale_reset_n) |-> low == RST_PULSE + 1 && cs_n; endproperty
  a_mid: assert property (p_mid) else $error("midscale pulse");
endmodule // pdc_host_checker
bind pdc_host pdc_host_checker #(.CLK_HALF(CLK_HALF), .CS_GAP(CS_GAP), .RST_PULSE(RST_PULSE)) chk (.clk, .srst,
  .rd_valid, .cs_n, .sclk, .serial_in_pin, .midscale_reset_n);

// >>> testbench.sv
// Self-checking bench for the chain host
// Assumes pdc_host, pdc_chain_model and the bound checker
`timescale 1ns/1ps
module testbench;
  reg clk = 1'b0, srst = 1'b1, wr_valid = 1'b0, wr_zc_gate = 1'b0, mute_req = 1'b0;
  reg midscale_req = 1'b0, unmute_req = 1'b0, zc_window = 1'b0;
  reg [6:0] wr_far = 7'h00, wr_near = 7'h00;
  wire wr_ready, rd_valid, busy, cs_n, sclk, serial_in_pin, midscale_reset_n, shutdown_n, chain_return_pin;
  wire [13:0] rd_data;
  wire [6:0] near_wiper, far_wiper;
  integer num_errors = 0, checks = 0, seed = 32'hef5d957d, i;
  reg [13:0] prev = 14'h0000, d, e;
  reg [13:0] q[$];
  initial forever #5 clk = ~clk;
  always @(negedge clk) zc_window <= ($random(seed) & 3) == 0;
  pdc_host #(.CLK_HALF(2), .CS_GAP(2), .RST_PULSE(2)) dut (.clk, .srst, .wr_valid, .wr_ready, .wr_far,
    .wr_near, .wr_zc_gate, .mute_req, .midscale_req, .unmute_req, .zc_window, .chain_return_pin, .rd_data,
    .rd_valid, .busy, .cs_n, .sclk, .serial_in_pin, .midscale_reset_n, .shutdown_n);
  pdc_chain_model chain (.cs_n, .sclk, .serial_in_pin, .midscale_reset_n, .shutdown_n,
    .chain_serial_out(chain_return_pin), .near_wiper, .far_wiper);
  task chk(input [13:0] got, input [13:0] want);
    begin
      checks = checks + 1;
      if (got !== want) begin
        num_errors = num_errors + 1;
        $display("mismatch at %0t: got %h want %h", $time, got, want);
      end
    end
  endtask
  task summarize;
    begin
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask
  task bound(input integer k);
    if (k > 20000) begin
      num_errors = num_errors + 1;
      summarize;
    end
  endtask
  task wr(input [13:0] v, input g);
    integer k;
    begin
      {wr_far, wr_near} = v;
      wr_zc_gate = g;
      wr_valid = 1'b1;
      for (k = 0; wr_ready !== 1'b1; k = k + 1) begin
        bound(k);
        @(negedge clk);
      end
      q.push_back(shutdown_n === 1'b0 ? {7'h7f, v[6:0]} : v);
      @(negedge clk);
    end
  endtask
  task idle;
    integer k;
    for (k = 0; busy !== 1'b0 || q.size() != 0; k = k + 1) begin
      bound(k);
      @(negedge clk);
    end
  endtask
  always @(negedge clk) if (rd_valid === 1'b1) begin
    e = q.pop_front();
    chk({far_wiper, near_wiper}, e);
    chk(rd_data, shutdown_n === 1'b0 ? 14'h3fff : prev);
    chk({13'h0000, busy}, 14'h0001);
    prev = e;
  end
  initial begin
    repeat (5) @(negedge clk);
    srst = 1'b0;
    chk({12'h000, wr_ready, busy}, 14'h0002);
    for (i = 0; i < 6; i = i + 1) begin
      d = $random(seed);
      wr(d, i > 3);
    end
    wr_valid = 1'b0;
    idle;
    $display("burst and gated writes done");
    mute_req = 1'b1;
    q.push_back(14'h3f80);
    @(negedge clk);
    mute_req = 1'b0;
    idle;
    chk({13'h0000, shutdown_n}, 14'h0000);
    wr(14'h1a5b, 1'b0);
    wr_valid = 1'b0;
    idle;
    unmute_req = 1'b1;
    @(negedge clk);
    unmute_req = 1'b0;
    repeat (3) @(negedge clk);
    chk({13'h0000, shutdown_n}, 14'h0001);
    $display("mute and preset done");
    midscale_req = 1'b1;
    for (i = 0; midscale_reset_n !== 1'b0; i = i + 1) begin
      bound(i);
      @(negedge clk);
    end
    midscale_req = 1'b0;
    idle;
    chk({far_wiper, near_wiper}, 14'h2040);
    prev = prev & ~14'h2040;
    wr(14'h3f81, 1'b0);
    wr_valid = 1'b0;
    idle;
    $display("midscale reset done");
    summarize;
  end
endmodule // testbench
